// *** hdl/agpc_top.sv ***
module agpc_top #(
  parameter int unsigned NPINS = 4
) (
  input  wire logic I_CLK,
  input  wire logic I_RSTN,
  input  wire logic I_CE,
  input  wire logic I_SCLK,
  input  wire logic I_CS_N,
  input  wire logic I_SDI,
  input  wire logic I_AUX_PIN_0_I,
  input  wire logic I_AUX_PIN_1_I,
  input  wire logic I_AUX_PIN_2_I,
  input  wire logic I_AUX_PIN_3_I,
  input  wire logic I_HIGH_ALARM,
  input  wire logic I_LOW_ALARM,
  input  wire logic I_MODE_PD,
  output logic      O_SDO,
  output logic      O_AUX_PIN_0_O,
  output logic      O_AUX_PIN_1_O,
  output logic      O_AUX_PIN_2_O,
  output logic      O_AUX_PIN_3_O,
  output logic      O_AUX_PIN_0_OE_N,
  output logic      O_AUX_PIN_1_OE_N,
  output logic      O_AUX_PIN_2_OE_N,
  output logic      O_AUX_PIN_3_OE_N,
  output logic      O_RANGE_SEL,
  output logic      O_POWERDOWN
);

  // ------------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------------
  if (NPINS != agpc_pkg::PIN_COUNT) begin : g_chk
    $error("agpc_top serves exactly four pins");
  end

  // ------------------------------------------------------------------
  // state types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] tg_s;
    logic [3:0] p1;
    logic [3:0] p2;
    logic       srst_pend;
    logic       pd_asg;
    logic       rng_asg;
    logic [2:0] alm;
    logic [3:0] dir;
    logic [3:0] out_pend;
    logic [3:0] general_output;
    logic       rb_pend;
    logic       rb_en;
    logic [3:0] general_input;
    logic       pd;
    logic [3:0] pin_o;
    logic [3:0] oe_n;
  } agpc_core_t;

  typedef struct packed {
    logic [3:0]  cnt;
    logic [14:0] sh;
    logic [15:0] txs;
  } agpc_lnk_t;

  typedef struct packed {
    logic [15:0] word;
    logic        tg;
  } agpc_rx_t;

  agpc_core_t c_q;
  agpc_core_t c_d;
  agpc_lnk_t  l_q;
  agpc_lnk_t  l_d;
  agpc_rx_t   r_q;
  agpc_rx_t   r_d;

  logic [3:0]  pin_i;
  logic        csf;
  logic        rxe;
  logic [3:0]  cmd;
  logic [3:0]  spec_out;
  logic [3:0]  spec_in;
  logic [3:0]  gen_in;
  logic [3:0]  drive;
  logic [3:0]  alm_val;
  logic [15:0] tx_word;
  logic        lnk_rst_n;

  assign pin_i = {I_AUX_PIN_3_I, I_AUX_PIN_2_I, I_AUX_PIN_1_I, I_AUX_PIN_0_I};
  assign csf   = c_q.cs_s[2] & ~c_q.cs_s[1];
  assign rxe   = c_q.tg_s[2] ^ c_q.tg_s[1];
  assign cmd   = r_q.word[agpc_pkg::CMD_HI:agpc_pkg::CMD_LO];

  // ------------------------------------------------------------------
  // pin function map
  // ------------------------------------------------------------------
  always_comb begin
    spec_out    = 4'h0;
    alm_val     = 4'h0;
    // pin 0: xx1 either alarm, 010 and 110 high alarm
    spec_out[0] = c_q.alm[0] | c_q.alm[1]; // see [RULE_10] [RULE_11] [RULE_13]
    alm_val[0]  = c_q.alm[0] ? (I_HIGH_ALARM | I_LOW_ALARM) : I_HIGH_ALARM;
    // pin 1: 100 and 110 low alarm
    spec_out[1] = c_q.alm[2] & ~c_q.alm[0]; // see [RULE_12] [RULE_13]
    alm_val[1]  = I_LOW_ALARM;
    spec_in     = {c_q.pd_asg, c_q.rng_asg, 2'b00}; // see [RULE_08] [RULE_09]
    // special functions override direction
    drive  = spec_out | (~spec_in & ~spec_out & c_q.dir); // see [RULE_14] [RULE_15]
    gen_in = ~spec_out & ~spec_in & ~c_q.dir; // see [RULE_01]
  end

  assign tx_word = c_q.rb_en ? {12'h000, c_q.general_input} : 16'h0000;

  // ------------------------------------------------------------------
  // core next state
  // ------------------------------------------------------------------
  always_comb begin
    c_d = c_q;
    if (I_CE) begin
      c_d.cs_s = {c_q.cs_s[1:0], I_CS_N};
      c_d.tg_s = {c_q.tg_s[1:0], r_q.tg};
      c_d.p1   = pin_i;
      c_d.p2   = c_q.p1;
      c_d.pin_o = (spec_out & alm_val) | (~spec_out & c_q.general_output); // see [RULE_01]
      c_d.oe_n  = ~drive;
      if (csf) begin
        if (c_q.srst_pend) begin
          // configuration and pin data registers back to reset; pd keeps its value
          c_d.srst_pend = 1'b0; // see [RULE_07]
          c_d.pd_asg    = 1'b0;
          c_d.rng_asg   = 1'b0;
          c_d.alm       = agpc_pkg::ALM_RST;
          c_d.dir       = agpc_pkg::DIR_RST;
          c_d.out_pend  = 4'h0;
          c_d.general_output       = 4'h0;
          c_d.rb_pend   = 1'b0;
          c_d.rb_en     = 1'b0;
          c_d.general_input       = 4'h0;
        end else begin
          c_d.general_output   = c_q.out_pend; // see [RULE_02]
          c_d.general_input   = c_q.p2 & gen_in; // see [RULE_03]
          c_d.rb_en = c_q.rb_pend; // see [RULE_03]
        end
        if (c_q.p2[3] && !I_MODE_PD) begin
          c_d.pd = 1'b0; // see [RULE_16]
        end
      end
      if (rxe) begin
        // reserved bits are not decoded
        if (cmd == agpc_pkg::CMD_PIN_CFG) begin // see [RULE_05] [RULE_06]
          c_d.srst_pend = r_q.word[agpc_pkg::SRST_BIT]; // see [RULE_07]
          c_d.pd_asg    = r_q.word[agpc_pkg::PD_BIT]; // see [RULE_08]
          c_d.rng_asg   = r_q.word[agpc_pkg::RNG_BIT]; // see [RULE_09]
          c_d.alm       = r_q.word[agpc_pkg::ALM_HI:agpc_pkg::ALM_LO];
          c_d.dir       = r_q.word[agpc_pkg::DIR_HI:agpc_pkg::DIR_LO]; // see [RULE_15]
          c_d.rb_pend   = 1'b0;
        end else begin
          // pin data only from non-config frames
          c_d.out_pend = r_q.word[agpc_pkg::OUT_HI:agpc_pkg::OUT_LO]; // see [RULE_04]
          c_d.rb_pend  = r_q.word[agpc_pkg::RBEN_BIT];
        end
      end
      // set wins over wake-up
      if (c_q.pd_asg && !c_q.p2[3]) begin
        c_d.pd = 1'b1; // see [RULE_16]
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      c_q      <= '0;
      c_q.cs_s <= 3'h7;
      c_q.oe_n <= 4'hf;
    end else begin
      c_q <= c_d;
    end
  end

  // ------------------------------------------------------------------
  // link side on the serial clock
  // ------------------------------------------------------------------
  assign lnk_rst_n = I_RSTN & ~I_CS_N;

  always_comb begin
    l_d     = l_q;
    l_d.cnt = l_q.cnt + 4'h1;
    l_d.sh  = {l_q.sh[13:0], I_SDI}; // see [RULE_17]
    if (l_q.cnt == agpc_pkg::BIT_FIRST) begin
      l_d.txs = {tx_word[14:0], 1'b0};
    end else begin
      l_d.txs = {l_q.txs[14:0], 1'b0};
    end
    r_d = r_q;
    if (l_q.cnt == agpc_pkg::BIT_LAST) begin
      r_d.word = {l_q.sh, I_SDI}; // see [RULE_17]
      r_d.tg   = ~r_q.tg;
    end
  end

  always_ff @(posedge I_SCLK or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  always_ff @(posedge I_SCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // sdo carries readback in every frame type
  assign O_SDO = (l_q.cnt == agpc_pkg::BIT_FIRST) ? tx_word[15] : l_q.txs[15]; // see [RULE_04]
  assign O_AUX_PIN_0_O    = c_q.pin_o[0];
  assign O_AUX_PIN_1_O    = c_q.pin_o[1];
  assign O_AUX_PIN_2_O    = c_q.pin_o[2];
  assign O_AUX_PIN_3_O    = c_q.pin_o[3];
  assign O_AUX_PIN_0_OE_N = c_q.oe_n[0];
  assign O_AUX_PIN_1_OE_N = c_q.oe_n[1];
  assign O_AUX_PIN_2_OE_N = c_q.oe_n[2];
  assign O_AUX_PIN_3_OE_N = c_q.oe_n[3];
  assign O_RANGE_SEL      = c_q.rng_asg & c_q.p2[2]; // see [RULE_09]
  // raw pin path powers down without waiting for a clock
  assign O_POWERDOWN      = c_q.pd | (c_q.pd_asg & ~I_AUX_PIN_3_I); // see [RULE_16]

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  AST_OUT_UPD: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_02]
    I_CE && csf && !c_q.srst_pend |=> c_q.general_output == $past(c_q.out_pend))
    else $error("output data not applied at frame start");

  AST_GPI_CAP: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_03]
    I_CE && csf && !c_q.srst_pend |=> c_q.general_input == $past(c_q.p2 & gen_in))
    else $error("input levels not latched at frame start");

  AST_CFG_DEC: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_05]
    I_CE && rxe && cmd == agpc_pkg::CMD_PIN_CFG
    |=> c_q.dir == $past(r_q.word[agpc_pkg::DIR_HI:agpc_pkg::DIR_LO])
    && c_q.alm == $past(r_q.word[agpc_pkg::ALM_HI:agpc_pkg::ALM_LO]))
    else $error("config frame not decoded");

  AST_NO_CFG: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_04]
    I_CE && rxe && cmd != agpc_pkg::CMD_PIN_CFG && !csf |=> $stable(c_q.dir))
    else $error("direction changed by a non-config frame");

  AST_SRST: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_07]
    I_CE && csf && c_q.srst_pend && !rxe
    |=> c_q.dir == 4'h0 && c_q.alm == 3'h0 && !c_q.pd_asg && c_q.general_output == 4'h0)
    else $error("soft reset did not clear registers");

  AST_PD_ASYNC: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_16]
    c_q.pd_asg && !I_AUX_PIN_3_I |-> O_POWERDOWN)
    else $error("power-down input ignored");

  AST_ALM0: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_10]
    I_CE && c_q.alm[0] && $stable(c_q.alm)
    ##1 $past(I_CE) |-> O_AUX_PIN_0_O == $past(I_HIGH_ALARM | I_LOW_ALARM) && !O_AUX_PIN_0_OE_N)
    else $error("pin 0 does not follow either alarm");

  AST_ALM1: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_12]
    I_CE && c_q.alm == agpc_pkg::ALM_LO_ONLY
    |=> O_AUX_PIN_1_O == $past(I_LOW_ALARM) && !O_AUX_PIN_1_OE_N)
    else $error("pin 1 does not follow low alarm");

  AST_ALM_BOTH: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_13]
    I_CE && c_q.alm == agpc_pkg::ALM_BOTH
    |=> O_AUX_PIN_0_O == $past(I_HIGH_ALARM) && O_AUX_PIN_1_O == $past(I_LOW_ALARM))
    else $error("alarm pair not driven");

  AST_OVERRIDE: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_14]
    I_CE && (c_q.pd_asg || c_q.rng_asg)
    |=> (!$past(c_q.pd_asg) || O_AUX_PIN_3_OE_N) && (!$past(c_q.rng_asg) || O_AUX_PIN_2_OE_N))
    else $error("assigned input pin is driven");

  AST_DIR_OUT: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_15]
    I_CE && c_q.dir[0] && c_q.alm == agpc_pkg::ALM_RST |=> !O_AUX_PIN_0_OE_N)
    else $error("output direction not applied");

  AST_RNG: assert property (@(posedge I_CLK) disable iff (!I_RSTN) // see [RULE_09]
    !c_q.rng_asg |-> !O_RANGE_SEL)
    else $error("range select without assignment");

  // next rise lands in the following frame, so only the block reset may cancel
  AST_RX16: assert property (@(posedge I_SCLK) disable iff (!I_RSTN) // see [RULE_17]
    l_q.cnt == agpc_pkg::BIT_LAST |=> r_q.word == $past({l_q.sh, I_SDI}))
    else $error("frame word not captured after 16 bits");

  COV_FRAME: cover property (@(posedge I_CLK) disable iff (!I_RSTN) I_CE && csf);
  COV_CFG: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
    rxe && cmd == agpc_pkg::CMD_PIN_CFG);
  COV_SRST: cover property (@(posedge I_CLK) disable iff (!I_RSTN) csf && c_q.srst_pend);
  COV_PD: cover property (@(posedge I_CLK) disable iff (!I_RSTN) c_q.pd);
  COV_ALM_BOTH: cover property (@(posedge I_CLK) disable iff (!I_RSTN)
    I_CE && c_q.alm == agpc_pkg::ALM_BOTH);

endmodule

// *** hdl/agpc_pkg.sv ***
// Overview of operation
// [RULE_01] four pins, each separately an output of host data or a readable input
// [RULE_02] at chip-select fall, output pins take data shifted in last frame
// [RULE_03] at chip-select fall, input pins are latched; returned on SDO if enabled
// [RULE_04] config frames keep SDO valid and carry no output pin data
// [RULE_05] command field 0100 writes the pin configuration register
// [RULE_06] host writes zeros to the two reserved bits below the command
// [RULE_07] soft reset bit returns every register to reset at next frame; pd is not cleared
// [RULE_08] power-down assign bit makes pin 3 the power-down input
// [RULE_09] range assign bit makes pin 2 the range select input
// [RULE_10] alarm field resets to 000; xx1 drives pin 0 with either alarm
// [RULE_11] alarm field 010 drives pin 0 with the high alarm only
// [RULE_12] alarm field 100 drives pin 1 with the low alarm
// [RULE_13] alarm field 110 drives pin 1 low alarm and pin 0 high alarm
// [RULE_14] direction bits apply only to pins without a special function
// [RULE_15] four lowest bits set pin directions, one is output, reset zero
// [RULE_16] assigned pin 3 low powers down at once; wakes at chip-select fall (code wakes there only while I_MODE_PD is low)
// [RULE_17] frames are 16 bits, MSB first, decoded after the last bit
package agpc_pkg;
  localparam int unsigned PIN_COUNT   = 4;
  localparam int unsigned FRAME_BITS  = 16;
  localparam logic [3:0]  CMD_PIN_CFG = 4'h4;
  localparam int unsigned CMD_HI      = 15;
  localparam int unsigned CMD_LO      = 12;
  localparam int unsigned RSV_HI      = 11;
  localparam int unsigned RSV_LO      = 10;
  localparam int unsigned SRST_BIT    = 9;
  localparam int unsigned PD_BIT      = 8;
  localparam int unsigned RNG_BIT     = 7;
  localparam int unsigned ALM_HI      = 6;
  localparam int unsigned ALM_LO      = 4;
  localparam int unsigned DIR_HI      = 3;
  localparam int unsigned DIR_LO      = 0;
  localparam int unsigned RBEN_BIT    = 4;
  localparam int unsigned OUT_HI      = 3;
  localparam int unsigned OUT_LO      = 0;
  localparam logic [2:0]  ALM_RST     = 3'h0;
  localparam logic [2:0]  ALM_HI_ONLY = 3'h2;
  localparam logic [2:0]  ALM_LO_ONLY = 3'h4;
  localparam logic [2:0]  ALM_BOTH    = 3'h6;
  localparam logic [3:0]  DIR_RST     = 4'h0;
  localparam logic [3:0]  BIT_LAST    = 4'hf;
  localparam logic [3:0]  BIT_FIRST   = 4'h0;
endpackage

// *** verification/agpc_host_model.sv ***
module agpc_host_model (
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------
  // serial master, clock idles low between frames
  // --------------------------------------------------------------
  int unsigned lead_ns = 100;

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end

  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    if (w[15:12] == 4'h4) w[11:10] = 2'h0;
    r = 16'h0000;
    // chip select moves after the system clock edge has sampled it
    o_cs_n <= 1'b0;
    #(lead_ns);
    for (int i = 15; i >= 0; i--) begin
      o_sdi = w[i];
      #7.5;
      r = {r[14:0], i_sdo};
      o_sclk = 1'b1;
      #7.5;
      o_sclk = 1'b0;
    end
    #20;
    o_cs_n <= 1'b1;
    // released line must not keep the last bit
    o_sdi = ~o_sdi;
  endtask
endmodule

// *** verification/adc_gpio_program_control_tb.sv ***
module adc_gpio_program_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;
  logic       rstn;
  logic       ce;
  logic       hi;
  logic       lo;
  logic       mpd;
  logic [3:0] pin_i;
  logic       cs_n;
  logic       sclk;
  logic       sdi;
  wire logic  sdo;
  wire logic  rng;
  wire logic  pd;
  wire logic [3:0] pin_o;
  wire logic [3:0] oe_n;
  logic [15:0] rd;
  int          fails;
  int          compares;

  agpc_top dut_u (.I_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_SDI(sdi), .I_AUX_PIN_0_I(pin_i[0]), .I_AUX_PIN_1_I(pin_i[1]),
    .I_AUX_PIN_2_I(pin_i[2]), .I_AUX_PIN_3_I(pin_i[3]), .I_HIGH_ALARM(hi),
    .I_LOW_ALARM(lo), .I_MODE_PD(mpd), .O_SDO(sdo), .O_AUX_PIN_0_O(pin_o[0]),
    .O_AUX_PIN_1_O(pin_o[1]), .O_AUX_PIN_2_O(pin_o[2]), .O_AUX_PIN_3_O(pin_o[3]),
    .O_AUX_PIN_0_OE_N(oe_n[0]), .O_AUX_PIN_1_OE_N(oe_n[1]), .O_AUX_PIN_2_OE_N(oe_n[2]),
    .O_AUX_PIN_3_OE_N(oe_n[3]), .O_RANGE_SEL(rng), .O_POWERDOWN(pd));

  agpc_host_model host_u (.o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi), .i_sdo(sdo));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // --------------------------------------------------------------
  // compare and report
  // --------------------------------------------------------------
  task automatic chk_w(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_v(input logic [3:0] e, input logic [3:0] g);
    chk_w({12'h000, e}, {12'h000, g});
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic frame(input logic [15:0] w);
    host_u.xfer(w, rd);
    repeat (8) @(posedge clk);
  endtask

  initial begin
    #200us;
    fails++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    logic [2:0] f;
    logic [1:0] a;
    logic       d0;
    logic       d1;
    logic       e0;
    fails = 0;
    compares = 0;
    rstn = 1'b0;
    ce = 1'b1;
    hi = 1'b0;
    lo = 1'b0;
    mpd = 1'b0;
    pin_i = 4'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk_v(4'hf, oe_n);
    chk_v(4'h0, {1'b0, rng, pd, sdo});
    chk_v(4'h0, pin_o);
    $display("test reset done");
    frame(16'h400f);
    chk_v(4'h0, oe_n);
    frame(16'h0009);
    chk_v(4'h0, pin_o);
    frame(16'h0006);
    chk_v(4'h9, pin_o);
    frame(16'h0000);
    chk_v(4'h6, pin_o);
    $display("test output data done");
    frame(16'h400a);
    pin_i <= 4'h5;
    chk_v(4'h5, oe_n);
    host_u.lead_ns = 400;
    frame(16'h001a);
    frame(16'h0000);
    chk_w(16'h0005, rd);
    chk_v(4'ha, pin_o & ~oe_n);
    frame(16'h0000);
    chk_w(16'h0000, rd);
    host_u.lead_ns = 100;
    $display("test readback done");
    for (int i = 1; i < 8; i++) begin
      f = 3'(i);
      frame({9'h080, f, 4'h0});
      for (int j = 0; j < 4; j++) begin
        a = 2'(j);
        @(posedge clk);
        hi <= a[0];
        lo <= a[1];
        repeat (3) @(posedge clk);
        d0 = f[0] | (f == 3'h2) | (f == 3'h6);
        d1 = (f == 3'h4) | (f == 3'h6);
        e0 = f[0] ? (a[0] | a[1]) : a[0];
        chk_v({2'b11, ~d1, ~d0}, oe_n);
        chk_v({3'h0, e0 & d0}, {3'h0, pin_o[0] & ~oe_n[0]});
        chk_v({3'h0, a[1] & d1}, {3'h0, pin_o[1] & ~oe_n[1]});
      end
    end
    hi <= 1'b0;
    lo <= 1'b0;
    $display("test alarm pins done");
    frame(16'h4084);
    chk_v(4'hf, oe_n);
    pin_i <= 4'h4;
    repeat (5) @(posedge clk);
    chk_v(4'h1, {3'h0, rng});
    // clock enable low freezes the synchronised pin level
    ce <= 1'b0;
    pin_i <= 4'h8;
    repeat (5) @(posedge clk);
    chk_v(4'h1, {3'h0, rng});
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    chk_v(4'h0, {3'h0, rng});
    $display("test range pin done");
    frame(16'h4108);
    chk_v(4'hf, oe_n);
    mpd <= 1'b1;
    chk_v(4'h0, {3'h0, pd});
    @(posedge clk);
    pin_i <= 4'h0;
    #1;
    chk_v(4'h1, {3'h0, pd});
    @(posedge clk);
    pin_i <= 4'h8;
    repeat (5) @(posedge clk);
    chk_v(4'h1, {3'h0, pd});
    frame(16'h0000);
    chk_v(4'h1, {3'h0, pd});
    mpd <= 1'b0;
    frame(16'h0000);
    chk_v(4'h0, {3'h0, pd});
    $display("test power-down done");
    frame(16'h420f);
    chk_v(4'h0, oe_n);
    frame(16'h0005);
    chk_v(4'hf, oe_n);
    chk_v(4'h0, pin_o);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule
